// ---- hdl/pio_pkg.sv ----
// shared constants of the parallel io port: register map, reset values, field encodings
`default_nettype none

// ****************************************************************
// package
// ****************************************************************
package pio_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned MAX_PINS = 8;
  localparam int unsigned NUM_VEC = 2;

  // register offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h01;
  localparam logic [7:0] OFS_OPT = 8'h02;
  localparam logic [7:0] OFS_IRQ_EN = 8'h03;
  localparam logic [7:0] OFS_EDGE = 8'h04;
  localparam logic [7:0] OFS_PENDING = 8'h05;

  // reset values
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_OPT = 8'h00;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [1:0] RST_EDGE = 2'h0;

  // field encodings
  localparam logic DIR_INPUT = 1'b0;
  localparam logic DIR_OUTPUT = 1'b1;
  localparam logic OPT_IN_FLOAT = 1'b0;
  localparam logic OPT_IN_PULLUP_IRQ = 1'b1;
  localparam logic OPT_OUT_OPEN_DRAIN = 1'b0;
  localparam logic OPT_OUT_PUSH_PULL = 1'b1;
  localparam logic EDGE_FALLING = 1'b0;
  localparam logic EDGE_RISING = 1'b1;

  // unmapped reads return this
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

endpackage

`default_nettype wire

// ---- hdl/pio_port.sv ----
// parallel io port: eight configurable pins, edge interrupts and alternate functions
//
// Behaviour
// - eight pins, bit x controls pin x
// - direction 0: read returns sampled pin
// - input option selects floating or pull-up
// - data write on input only updates latch
// - pin enable bit arms external interrupt
// - per-vector falling or rising edge select
// - several pins share one vector request
// - vector fetch clears latched request
// - changing edge select clears pending requests
// - direction 1: latch driven onto pin
// - output mode read returns latch value
// - output option selects push-pull or open-drain
// - latch 0 drives low; 1 high or released
// - peripheral output overrides port settings
// - alternate output: read returns pin state
// - floating input feeds peripheral alternate input
// - pull-up and high driver only where selected
// - absent option bit: direction alone decides
// - option encodings per direction
// - reset clears data, direction, option
// - enabled edges stay able to wake device
//
// The register offsets and strobed register access were left to the implementer.
`default_nettype none

module pio_port #(
  parameter int unsigned NUM_PINS    = 8,
  parameter logic [7:0]  OPT_PRESENT = 8'hFF,
  parameter logic [7:0]  PIN_ON_VEC1 = 8'hF0
) (
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  input  wire logic [pio_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [pio_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output var  logic [pio_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic [NUM_PINS-1:0]          pin_in,
  output var  logic [NUM_PINS-1:0]          pin_out,
  output var  logic [NUM_PINS-1:0]          pin_oe,
  output var  logic [NUM_PINS-1:0]          pull_up_en,
  input  wire logic [NUM_PINS-1:0]          alt_out_en,
  input  wire logic [NUM_PINS-1:0]          alt_out_val,
  output var  logic [NUM_PINS-1:0]          alt_in,
  output logic      [pio_pkg::NUM_VEC-1:0]  irq_req,
  input  wire logic [pio_pkg::NUM_VEC-1:0]  vector_fetch,
  output logic                              wake_req
);
  import pio_pkg::*;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (NUM_PINS < 1 || NUM_PINS > MAX_PINS) begin : g_bad_pins
    $error("pio_port: NUM_PINS must lie between 1 and 8");
  end

  // the read mux widens pin vectors into one data word
  if (MAX_PINS > DATA_W) begin : g_bad_width
    $error("pio_port: data word narrower than the pin count");
  end

  // the request logic below is written out for exactly two vectors
  if (NUM_VEC != 2) begin : g_bad_vec
    $error("pio_port: exactly two interrupt vectors are served");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [DATA_W-1:0] widen(input logic [NUM_PINS-1:0] v);
    logic [DATA_W-1:0] w;
    w = '0;
    w[NUM_PINS-1:0] = v;
    widen = w;
  endfunction

  localparam logic [NUM_PINS-1:0] OPT_MASK = OPT_PRESENT[NUM_PINS-1:0];
  localparam logic [NUM_PINS-1:0] VEC1_MASK = PIN_ON_VEC1[NUM_PINS-1:0];

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [NUM_PINS-1:0] pin_data_latch;
  logic [NUM_PINS-1:0] pin_direction_bit;
  logic [NUM_PINS-1:0] pin_option;
  logic [NUM_PINS-1:0] ext_irq_pin_enable;
  logic [NUM_VEC-1:0]  ext_irq_edge_select;

  logic wr_data;
  logic wr_dir;
  logic wr_opt;
  logic wr_irq_en;
  logic wr_edge;
  logic edge_changed;

  assign wr_data = reg_wr && hit(reg_addr, OFS_DATA);
  assign wr_dir = reg_wr && hit(reg_addr, OFS_DIR);
  assign wr_opt = reg_wr && hit(reg_addr, OFS_OPT);
  assign wr_irq_en = reg_wr && hit(reg_addr, OFS_IRQ_EN);
  assign wr_edge = reg_wr && hit(reg_addr, OFS_EDGE);
  assign edge_changed = wr_edge && (reg_wdata[NUM_VEC-1:0] != ext_irq_edge_select);

  // the latch always takes writes, even on inputs, so a later switch to output drives it at once
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_data_latch <= RST_DATA[NUM_PINS-1:0];
    end else if (wr_data) begin
      pin_data_latch <= reg_wdata[NUM_PINS-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_direction_bit <= RST_DIR[NUM_PINS-1:0];
    end else if (wr_dir) begin
      pin_direction_bit <= reg_wdata[NUM_PINS-1:0];
    end
  end

  // absent option bits stay at zero and ignore writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_option <= RST_OPT[NUM_PINS-1:0];
    end else if (wr_opt) begin
      pin_option <= reg_wdata[NUM_PINS-1:0] & OPT_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_irq_pin_enable <= RST_IRQ_EN[NUM_PINS-1:0];
    end else if (wr_irq_en) begin
      ext_irq_pin_enable <= reg_wdata[NUM_PINS-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_irq_edge_select <= RST_EDGE;
    end else if (wr_edge) begin
      ext_irq_edge_select <= reg_wdata[NUM_VEC-1:0];
    end
  end

  // ****************************************************************
  // input synchroniser
  // ****************************************************************
  logic [NUM_PINS-1:0] pin_meta;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] pin_prev;

  // pin_meta is read by pin_sync only
  // no reset here: a zero reset value would fake a rising edge on a pin that idles high
  always_ff @(posedge core_clk) begin
    pin_meta <= pin_in;
    pin_sync <= pin_meta;
  end

  // ****************************************************************
  // edge history
  // ****************************************************************
  // also free of reset, so it agrees with the pin once reset ends
  always_ff @(posedge core_clk) begin
    pin_prev <= pin_sync;
  end

  // ****************************************************************
  // per-pin pad control
  // ****************************************************************
  logic [NUM_PINS-1:0] is_output;
  logic [NUM_PINS-1:0] push_pull;
  logic [NUM_PINS-1:0] pullup_sel;
  logic [NUM_PINS-1:0] next_pin_out;
  logic [NUM_PINS-1:0] next_pin_oe;
  logic [NUM_PINS-1:0] next_pull_up;
  logic [NUM_PINS-1:0] irq_armed;
  logic [NUM_PINS-1:0] rise;
  logic [NUM_PINS-1:0] fall;
  logic [NUM_PINS-1:0] pin_event;
  logic [NUM_PINS-1:0] read_view;
  logic [NUM_PINS-1:0] next_alt_in;

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    // an enabled peripheral output forces the pin to output push-pull
    assign is_output[i] = alt_out_en[i] || (pin_direction_bit[i] == DIR_OUTPUT);
    // without an option bit an output is push-pull and an input floats
    assign push_pull[i] = alt_out_en[i] || !OPT_MASK[i] || (pin_option[i] == OPT_OUT_PUSH_PULL);
    assign pullup_sel[i] = !is_output[i] && OPT_MASK[i] && (pin_option[i] == OPT_IN_PULLUP_IRQ);

    always_comb begin
      next_pin_out[i] = 1'b0;
      next_pin_oe[i] = 1'b0;
      if (alt_out_en[i]) begin
        next_pin_out[i] = alt_out_val[i];
        next_pin_oe[i] = 1'b1;
      end else if (is_output[i]) begin
        // low is always driven; high only when push-pull
        next_pin_out[i] = pin_data_latch[i];
        next_pin_oe[i] = !pin_data_latch[i] || push_pull[i];
      end
    end

    assign next_pull_up[i] = pullup_sel[i];

    // option 1 in input mode means interrupt capable; pins without an option bit need only the enable
    assign irq_armed[i] = !is_output[i] && ext_irq_pin_enable[i] &&
                          (!OPT_MASK[i] || (pin_option[i] == OPT_IN_PULLUP_IRQ));
    assign rise[i] = pin_sync[i] && !pin_prev[i];
    assign fall[i] = !pin_sync[i] && pin_prev[i];
    assign pin_event[i] = irq_armed[i] &&
                          ((ext_irq_edge_select[VEC1_MASK[i]] == EDGE_RISING) ? rise[i] : fall[i]);

    // inputs and peripheral-driven pins read the pin; port outputs read the latch
    assign read_view[i] = (is_output[i] && !alt_out_en[i]) ? pin_data_latch[i] : pin_sync[i];

    // peripherals see the pin on floating inputs and the latch on port outputs
    always_comb begin
      next_alt_in[i] = 1'b0;
      if (is_output[i] && !alt_out_en[i]) begin
        next_alt_in[i] = pin_data_latch[i];
      end else if (!is_output[i] && !pullup_sel[i]) begin
        next_alt_in[i] = pin_sync[i];
      end
    end
  end

  // ****************************************************************
  // pad registers
  // ****************************************************************
  // pad outputs are registered so the pins never glitch on decode paths
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_out <= '0;
    end else begin
      pin_out <= next_pin_out;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_oe <= '0;
    end else begin
      pin_oe <= next_pin_oe;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pull_up_en <= '0;
    end else begin
      pull_up_en <= next_pull_up;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      alt_in <= '0;
    end else begin
      alt_in <= next_alt_in;
    end
  end

  // ****************************************************************
  // external interrupt requests
  // ****************************************************************
  logic [NUM_VEC-1:0] vec_event;
  logic [NUM_VEC-1:0] next_irq_req;

  assign vec_event[0] = |(pin_event & ~VEC1_MASK);
  assign vec_event[1] = |(pin_event & VEC1_MASK);

  // a new edge in the cycle of a clear still latches
  always_comb begin
    next_irq_req = irq_req;
    if (edge_changed) begin
      next_irq_req = '0;
    end
    next_irq_req = next_irq_req & ~vector_fetch;
    next_irq_req = next_irq_req | vec_event;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_req <= '0;
    end else begin
      irq_req <= next_irq_req;
    end
  end

  // any pending request may end a low power mode; the port itself keeps its state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= |next_irq_req;
    end
  end

  // ****************************************************************
  // register read
  // ****************************************************************
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = READ_UNMAPPED;
    if (reg_rd) begin
      if (hit(reg_addr, OFS_DATA)) begin
        next_rdata = widen(read_view);
      end else if (hit(reg_addr, OFS_DIR)) begin
        next_rdata = widen(pin_direction_bit);
      end else if (hit(reg_addr, OFS_OPT)) begin
        next_rdata = widen(pin_option);
      end else if (hit(reg_addr, OFS_IRQ_EN)) begin
        next_rdata = widen(ext_irq_pin_enable);
      end else if (hit(reg_addr, OFS_EDGE)) begin
        next_rdata[NUM_VEC-1:0] = ext_irq_edge_select;
      end else if (hit(reg_addr, OFS_PENDING)) begin
        next_rdata[NUM_VEC-1:0] = irq_req;
      end
    end
  end

  // read data stand for the one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// ---- tb/pio_port_properties.sv ----
// port-level assertions of the parallel io port
`default_nettype none

// ********
// checker
// ********
module pio_port_properties #(
  parameter int unsigned NUM_PINS = 8
) (
  input wire logic                         core_clk,
  input wire logic                         rst,
  input wire logic [pio_pkg::ADDR_W-1:0]   reg_addr,
  input wire logic [pio_pkg::DATA_W-1:0]   reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [pio_pkg::DATA_W-1:0]   reg_rdata,
  input wire logic [NUM_PINS-1:0]          pin_in,
  input wire logic [NUM_PINS-1:0]          pin_out,
  input wire logic [NUM_PINS-1:0]          pin_oe,
  input wire logic [NUM_PINS-1:0]          pull_up_en,
  input wire logic [NUM_PINS-1:0]          alt_out_en,
  input wire logic [NUM_PINS-1:0]          alt_out_val,
  input wire logic [NUM_PINS-1:0]          alt_in,
  input wire logic [pio_pkg::NUM_VEC-1:0]  irq_req,
  input wire logic [pio_pkg::NUM_VEC-1:0]  vector_fetch,
  input wire logic                         wake_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import pio_pkg::*;
  // shadow of the edge select, so a changing write can be told from a repeat
  logic [NUM_VEC-1:0] edge_seen;
  always_ff @(posedge core_clk) begin
    if (rst) edge_seen <= RST_EDGE;
    else if (reg_wr && reg_addr == OFS_EDGE) edge_seen <= reg_wdata[NUM_VEC-1:0];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_alt_override: assert property (
    !$past(rst) |-> ((pin_oe & $past(alt_out_en)) == $past(alt_out_en))
      && (((pin_out ^ $past(alt_out_val)) & $past(alt_out_en)) == '0))
    else $error("peripheral output not forced onto pad");
  chk_irq_cause: assert property (
    $rose(irq_req[0]) |-> $past(pin_in[3:0], 3) != $past(pin_in[3:0], 4))
    else $error("request without a synchronised pin edge");
  chk_clear_cause: assert property (
    $fell(irq_req[0]) |-> $past(vector_fetch[0]) || $past(reg_wr && reg_addr == OFS_EDGE))
    else $error("request dropped without fetch or edge change");
  // an edge reaching the detector in the clearing cycle still latches, so only quiet pins must clear
  chk_fetch_clears: assert property (
    |vector_fetch && $past(pin_in, 2) == $past(pin_in, 3) |=> (irq_req & $past(vector_fetch)) == '0)
    else $error("fetched vector still requesting");
  chk_edge_clears: assert property (
    reg_wr && reg_addr == OFS_EDGE && reg_wdata[NUM_VEC-1:0] != edge_seen && $past(pin_in, 2) == $past(pin_in, 3)
      |=> irq_req == '0)
    else $error("edge change left a request pending");
  chk_wake_follows: assert property (wake_req == (|irq_req))
    else $error("wake request differs from pending requests");
  chk_pullup_input: assert property (
    (pull_up_en & pin_oe & ~$past(alt_out_en)) == '0)
    else $error("pull-up on a driven pin");
  chk_rdata_pulse: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
endmodule

bind pio_port pio_port_properties #(.NUM_PINS(NUM_PINS)) i_pio_port_properties (.core_clk, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe, .pull_up_en,
  .alt_out_en, .alt_out_val, .alt_in, .irq_req, .vector_fetch, .wake_req);
`default_nettype wire

// ---- tb/pio_pad_model.sv ----
// board side of the pads: external drivers, pull-ups and floating lines
`default_nettype none

module pio_pad_model #(
  parameter int unsigned NUM_PINS = 8
) (
  input  wire logic                 core_clk,
  input  wire logic [NUM_PINS-1:0]  pin_out,
  input  wire logic [NUM_PINS-1:0]  pin_oe,
  input  wire logic [NUM_PINS-1:0]  pull_up_en,
  input  wire logic [NUM_PINS-1:0]  ext_val,
  input  wire logic [NUM_PINS-1:0]  ext_en,
  output var  logic [NUM_PINS-1:0]  pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // an undriven line flips every cycle so no test can lean on a stale level
  logic [NUM_PINS-1:0] drift = '0;
  always @(posedge core_clk) drift <= ~pin_in;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pull_up_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = drift[i];
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench of the parallel io port
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pio_pkg::*;
  logic       core_clk, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, wake_req;
  logic [7:0] reg_addr = '0, reg_wdata = '0, alt_out_en = '0, alt_out_val = '0;
  logic [7:0] ext_val = '0, ext_en = 8'hFF, reg_rdata, pin_in, pin_out, pin_oe, pull_up_en, alt_in;
  logic [1:0] vector_fetch = '0, irq_req;
  int         fail_count = 0, checks_done = 0;

  pio_port i_pio_port (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in,
    .pin_out, .pin_oe, .pull_up_en, .alt_out_en, .alt_out_val, .alt_in, .irq_req, .vector_fetch, .wake_req);
  pio_pad_model i_pio_pad_model (.core_clk, .pin_out, .pin_oe, .pull_up_en, .ext_val, .ext_en, .pin_in);

  // ********
  // helpers
  // ********
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // bounded wait: a request that never comes ends the run
  task automatic wait_irq(input logic [1:0] exp);
    int n;
    for (n = 0; n < 8 && irq_req !== exp; n++) cyc(1);
    #1;
    if (n == 8) begin
      fail_count++;
      wrap_up();
    end
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    ext_en <= 8'hFF; // board lines back to a known low level
    ext_val <= 8'h00;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_reset();
    for (int a = 0; a < 7; a++) rdchk(8'(a), 8'h00);
    chk(pin_oe | pull_up_en | 8'(irq_req), 8'h00);
    $display("reset test done");
  endtask
  task automatic t_output();
    ext_en <= 8'h00;
    wr(OFS_DATA, 8'hA5);
    wr(OFS_OPT, 8'hFF);
    wr(OFS_DIR, 8'hFF);
    cyc(1);
    chk(pin_oe, 8'hFF);
    chk(pin_out, 8'hA5);
    rdchk(OFS_DATA, 8'hA5);
    wr(OFS_OPT, 8'h00);
    cyc(1);
    chk(pin_oe, 8'h5A);
    chk(pin_out & pin_oe | pull_up_en, 8'h00);
    $display("output test done");
  endtask
  task automatic t_input();
    ext_en <= 8'hF0;
    ext_val <= 8'h30;
    wr(OFS_DIR, 8'h00);
    wr(OFS_OPT, 8'h0F);
    wr(OFS_DATA, 8'hFF);
    cyc(4);
    chk(pin_oe, 8'h00);
    chk(pull_up_en, 8'h0F);
    chk(alt_in, 8'h30);
    rdchk(OFS_DATA, 8'h3F);
    $display("input test done");
  endtask
  task automatic t_irq();
    ext_en <= 8'hFF;
    cyc(4);
    wr(OFS_OPT, 8'h13);
    wr(OFS_IRQ_EN, 8'h13);
    wr(OFS_EDGE, 8'h01);
    ext_val <= 8'h21;
    wait_irq(2'h3);
    chk({7'h00, wake_req}, 8'h01);
    rdchk(OFS_PENDING, 8'h03);
    @(posedge core_clk) vector_fetch <= 2'h1;
    @(posedge core_clk) vector_fetch <= 2'h0;
    #1 chk(8'(irq_req), 8'h02);
    ext_val <= 8'h25;
    cyc(5);
    chk(8'(irq_req), 8'h02);
    ext_val <= 8'h27;
    wait_irq(2'h3);
    chk(8'(irq_req), 8'h03);
    wr(OFS_EDGE, 8'h03);
    cyc(1);
    chk(8'(irq_req), 8'h00);
    ext_val <= 8'h37;
    wait_irq(2'h2);
    chk(8'(irq_req), 8'h02);
    wr(OFS_IRQ_EN, 8'h00);
    $display("interrupt test done");
  endtask
  task automatic t_alt();
    @(posedge core_clk);
    ext_en <= 8'h7F;
    alt_out_val <= 8'h80;
    alt_out_en <= 8'h80;
    cyc(4);
    chk(pin_oe & pin_out & 8'h80, 8'h80);
    rdchk(OFS_DATA, 8'hB7);
    @(posedge core_clk);
    alt_out_en <= 8'h00;
    $display("alternate test done");
  endtask

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_output();
    t_input();
    t_irq();
    t_alt();
    do_reset();
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
